/* File: design/boot_inq_resp.sv */
// Responder for the user-array blank check and the boot state inquiry.
// Assumes byte strobes from a serial receiver and a transmitter with ready.
`timescale 1ns/10ps
module boot_inq_resp #(
    parameter int ADDR_W      = boot_inq_pkg::ADDR_W_DEF,
    parameter int ARRAY_BYTES = boot_inq_pkg::ARRAY_BYTES_DEF
) (
    input  wire logic              MCLK,
    input  wire logic              RST_B,
    input  wire logic              CE,
    input  wire logic              RX_VALID,
    input  wire logic [7:0]        RX_DATA,
    input  wire logic              TX_READY,
    output logic                   TX_VALID,
    output logic [7:0]             TX_DATA,
    output logic                   CMD_PASS,
    output logic [7:0]             CMD_PASS_DATA,
    output logic                   BUSY,
    input  wire logic [2:0]        BOOT_PHASE,
    input  wire logic              ERR_EVENT,
    input  wire logic [7:0]        ERR_CODE_IN,
    input  wire logic              ERR_CLEAR,
    output logic                   ERR_FLAG,
    output logic [7:0]             LAST_ERR,
    output logic [ADDR_W-1:0]      FLASH_ADDR,
    output logic                   FLASH_RD,
    input  wire logic [7:0]        FLASH_RDATA,
    input  wire logic              FLASH_RVALID
);
    typedef enum logic [1:0] {M_IDLE, M_SCAN, M_SEND} main_state_e;

    typedef struct packed {
        main_state_e                st;
        logic [4:0][7:0]            frm;
        logic [2:0]                 len;
        logic [2:0]                 idx;
        logic                       tx_valid;
        logic [7:0]                 tx_data;
        logic                       pass;
        logic [7:0]                 pass_data;
        logic                       start;
        logic                       err_flag;
        logic [7:0]                 last_err;
        logic                       busy;
    } main_s;

    main_s r_q;
    main_s r_d;

    scan_if #(.ADDR_W(ADDR_W)) sif ();

    // Refuse geometry the scanner cannot address
    if (ADDR_W < 1 || ADDR_W > 32)
    begin : g_chk
        $error("boot_inq_resp: ADDR_W out of range");
    end

    blank_scan #(
        .ADDR_W      (ADDR_W),
        .ARRAY_BYTES (ARRAY_BYTES)
    ) u_scan (
        .clk    (MCLK),
        .rst_b  (RST_B),
        .ce     (CE),
        .rdata  (FLASH_RDATA),
        .rvalid (FLASH_RVALID),
        .sif    (sif)
    );

    // Map the current boot phase onto its reported state code
    function automatic logic [7:0] state_code(input logic [2:0] ph);
        logic [7:0] c;
        c = boot_inq_pkg::ST_DEV_SEL;
        case (ph)
            boot_inq_pkg::PH_DEV_SEL:    c = boot_inq_pkg::ST_DEV_SEL;
            boot_inq_pkg::PH_CLK_SEL:    c = boot_inq_pkg::ST_CLK_SEL;
            boot_inq_pkg::PH_RATE_SEL:   c = boot_inq_pkg::ST_RATE_SEL;
            boot_inq_pkg::PH_PE_TRANS:   c = boot_inq_pkg::ST_PE_TRANS;
            boot_inq_pkg::PH_PROG_ERASE: c = boot_inq_pkg::ST_PROG_ERASE;
            boot_inq_pkg::PH_PE_SEL:     c = boot_inq_pkg::ST_PE_SEL;
            boot_inq_pkg::PH_PROG_DATA:  c = boot_inq_pkg::ST_PROG_DATA;
            boot_inq_pkg::PH_ERASE_BLK:  c = boot_inq_pkg::ST_ERASE_BLK;
            default:                     c = boot_inq_pkg::ST_DEV_SEL;
        endcase
        return c;
    endfunction : state_code

    // Known error codes; anything else is logged as an unknown command
    function automatic logic [7:0] legal_err(input logic [7:0] e);
        logic [7:0] c;
        c = boot_inq_pkg::EC_UNKNOWN_CMD;
        case (e)
            boot_inq_pkg::EC_NONE,
            boot_inq_pkg::EC_SUM,
            boot_inq_pkg::EC_PROG_SIZE,
            boot_inq_pkg::EC_BLOCK_NUM,
            boot_inq_pkg::EC_ADDRESS,
            boot_inq_pkg::EC_DATA_LEN,
            boot_inq_pkg::EC_ERASE,
            boot_inq_pkg::EC_ERASE_INCOMP,
            boot_inq_pkg::EC_PROGRAM,
            boot_inq_pkg::EC_SEL_PROC,
            boot_inq_pkg::EC_RATE_CONFIRM:  c = e;
            boot_inq_pkg::EC_DEV_CODE,
            boot_inq_pkg::EC_CLK_MODE,
            boot_inq_pkg::EC_BIT_RATE,
            boot_inq_pkg::EC_IN_FREQ,
            boot_inq_pkg::EC_MULT_RATIO,
            boot_inq_pkg::EC_OP_FREQ:       c = e;
            default:                        c = boot_inq_pkg::EC_UNKNOWN_CMD;
        endcase
        return c;
    endfunction : legal_err

    // Command decode, frame building and byte-by-byte transmission
    always_comb
    begin
        logic [7:0] st_code;
        logic [7:0] err_byte;
        logic       set_err;
        logic [7:0] set_code;
        st_code  = state_code(BOOT_PHASE);
        err_byte = r_q.err_flag ? boot_inq_pkg::ERR_STATUS_BAD
                                : boot_inq_pkg::ERR_STATUS_OK;
        set_err  = 1'b0;
        set_code = boot_inq_pkg::EC_NONE;
        r_d       = r_q;
        r_d.pass  = 1'b0;
        r_d.start = 1'b0;

        case (r_q.st)
            M_IDLE:
            begin
                if (RX_VALID)
                begin
                    if (RX_DATA == boot_inq_pkg::CMD_BLANK_USER)
                    begin
                        r_d.start = 1'b1;
                        r_d.st    = M_SCAN;
                    end
                    else if (RX_DATA == boot_inq_pkg::CMD_STATE_INQ)
                    begin
                        // Phase only names selection or program/erase states
                        r_d.frm[0] = boot_inq_pkg::RSP_STATE;
                        r_d.frm[1] = boot_inq_pkg::RSP_STATE_SIZE;
                        r_d.frm[2] = st_code;
                        r_d.frm[3] = err_byte;
                        r_d.frm[4] = 8'(8'h00 - boot_inq_pkg::RSP_STATE
                                     - boot_inq_pkg::RSP_STATE_SIZE
                                     - st_code - err_byte);
                        r_d.len    = 3'(boot_inq_pkg::FRAME_MAX);
                        r_d.idx    = 3'h0;
                        r_d.st     = M_SEND;
                    end
                    else
                    begin
                        // Other boot commands belong to the earlier stages
                        r_d.pass      = 1'b1;
                        r_d.pass_data = RX_DATA;
                    end
                end
            end
            M_SCAN:
            begin
                if (sif.done)
                begin
                    r_d.idx = 3'h0;
                    r_d.st  = M_SEND;
                    if (sif.blank)
                    begin
                        r_d.frm[0] = boot_inq_pkg::RSP_ACK;
                        r_d.len    = 3'h1;
                    end
                    else
                    begin
                        r_d.frm[0] = boot_inq_pkg::RSP_BLANK_ERR;
                        r_d.frm[1] = boot_inq_pkg::EC_ERASE_INCOMP;
                        r_d.len    = 3'h2;
                        set_err    = 1'b1;
                        set_code   = boot_inq_pkg::EC_ERASE_INCOMP;
                    end
                end
            end
            M_SEND:
            begin
                // One byte in flight; the next waits for the transmitter
                if (!r_q.tx_valid)
                begin
                    r_d.tx_valid = 1'b1;
                    r_d.tx_data  = r_q.frm[r_q.idx];
                end
                else if (TX_READY)
                begin
                    r_d.tx_valid = 1'b0;
                    if (r_q.idx == r_q.len - 3'h1)
                    begin
                        r_d.st = M_IDLE;
                    end
                    else
                    begin
                        r_d.idx = r_q.idx + 3'h1;
                    end
                end
            end
            default:
            begin
                r_d.st = M_IDLE;
            end
        endcase

        // External errors; a set in the same cycle as a clear wins
        if (ERR_EVENT && !set_err)
        begin
            set_code = legal_err(ERR_CODE_IN);
            set_err  = (set_code != boot_inq_pkg::EC_NONE);
        end
        if (set_err)
        begin
            r_d.err_flag = 1'b1;
            r_d.last_err = set_code;
        end
        else if (ERR_CLEAR)
        begin
            r_d.err_flag = 1'b0;
            r_d.last_err = boot_inq_pkg::EC_NONE;
        end

        r_d.busy = (r_d.st != M_IDLE);
    end

    // State register; CE low freezes everything
    always_ff @(posedge MCLK)
    begin
        if (!RST_B)
        begin
            r_q <= '{st: M_IDLE, frm: '0, len: 3'h0, idx: 3'h0, tx_valid: 1'b0,
                     tx_data: 8'h00, pass: 1'b0, pass_data: 8'h00, start: 1'b0,
                     err_flag: 1'b0, last_err: 8'h00, busy: 1'b0};
        end
        else if (CE)
        begin
            r_q <= r_d;
        end
    end

    assign sif.start     = r_q.start;
    assign TX_VALID      = r_q.tx_valid;
    assign TX_DATA       = r_q.tx_data;
    assign CMD_PASS      = r_q.pass;
    assign CMD_PASS_DATA = r_q.pass_data;
    assign BUSY          = r_q.busy;
    assign ERR_FLAG      = r_q.err_flag;
    assign LAST_ERR      = r_q.last_err;
    assign FLASH_ADDR    = sif.addr;
    assign FLASH_RD      = sif.rd;

endmodule : boot_inq_resp

/* File: design/boot_inq_pkg.sv */
// Package of constants for the blank-check and state-inquiry responder.
// Assumes byte-wide command and response streams on a single clock.
package boot_inq_pkg;

    // Command bytes received from the host tool
    localparam logic [7:0] CMD_BLANK_USER  = 8'h4d;
    localparam logic [7:0] CMD_STATE_INQ   = 8'h4f;

    // Response header bytes, and the value of an erased flash byte
    localparam logic [7:0] RSP_ACK         = 8'h06;
    localparam logic [7:0] RSP_BLANK_ERR   = 8'hcd;
    localparam logic [7:0] RSP_STATE       = 8'h5f;
    localparam logic [7:0] RSP_STATE_SIZE  = 8'h02;
    localparam logic [7:0] ERASED_BYTE     = 8'hff;

    // Error-status byte values in the state reply
    localparam logic [7:0] ERR_STATUS_OK   = 8'h00;
    localparam logic [7:0] ERR_STATUS_BAD  = 8'h01;

    // State codes
    localparam logic [7:0] ST_DEV_SEL      = 8'h11;
    localparam logic [7:0] ST_CLK_SEL      = 8'h12;
    localparam logic [7:0] ST_RATE_SEL     = 8'h13;
    localparam logic [7:0] ST_PE_TRANS     = 8'h1f;
    localparam logic [7:0] ST_PROG_ERASE   = 8'h31;
    localparam logic [7:0] ST_PE_SEL       = 8'h3f;
    localparam logic [7:0] ST_PROG_DATA    = 8'h4f;
    localparam logic [7:0] ST_ERASE_BLK    = 8'h5f;

    // Boot phase indices driven by the rest of the responder
    localparam logic [2:0] PH_DEV_SEL      = 3'h0;
    localparam logic [2:0] PH_CLK_SEL      = 3'h1;
    localparam logic [2:0] PH_RATE_SEL     = 3'h2;
    localparam logic [2:0] PH_PE_TRANS     = 3'h3;
    localparam logic [2:0] PH_PROG_ERASE   = 3'h4;
    localparam logic [2:0] PH_PE_SEL       = 3'h5;
    localparam logic [2:0] PH_PROG_DATA    = 3'h6;
    localparam logic [2:0] PH_ERASE_BLK    = 3'h7;

    // Error codes
    localparam logic [7:0] EC_NONE         = 8'h00;
    localparam logic [7:0] EC_SUM          = 8'h11;
    localparam logic [7:0] EC_PROG_SIZE    = 8'h12;
    localparam logic [7:0] EC_DEV_CODE     = 8'h21;
    localparam logic [7:0] EC_CLK_MODE     = 8'h22;
    localparam logic [7:0] EC_BIT_RATE     = 8'h24;
    localparam logic [7:0] EC_IN_FREQ      = 8'h25;
    localparam logic [7:0] EC_MULT_RATIO   = 8'h26;
    localparam logic [7:0] EC_OP_FREQ      = 8'h27;
    localparam logic [7:0] EC_BLOCK_NUM    = 8'h29;
    localparam logic [7:0] EC_ADDRESS      = 8'h2a;
    localparam logic [7:0] EC_DATA_LEN     = 8'h2b;
    localparam logic [7:0] EC_ERASE        = 8'h51;
    localparam logic [7:0] EC_ERASE_INCOMP = 8'h52;
    localparam logic [7:0] EC_PROGRAM      = 8'h53;
    localparam logic [7:0] EC_SEL_PROC     = 8'h54;
    localparam logic [7:0] EC_UNKNOWN_CMD  = 8'h80;
    localparam logic [7:0] EC_RATE_CONFIRM = 8'hff;

    // Default flash array geometry
    localparam int         ARRAY_BYTES_DEF = 262144;
    localparam int         ADDR_W_DEF      = 18;

    // Longest response frame in bytes
    localparam int         FRAME_MAX       = 5;

endpackage : boot_inq_pkg

/* File: design/scan_if.sv */
// Interface between the command responder and the flash blank scanner.
// Assumes both ends share one clock; all signals are synchronous.
`timescale 1ns/10ps
interface scan_if #(
    parameter int ADDR_W = 18
);
    logic              start;
    logic              done;
    logic              blank;
    logic [ADDR_W-1:0] addr;
    logic              rd;

    modport ctrl (output start, input done, input blank, input addr, input rd);
    modport scan (input start, output done, output blank, output addr, output rd);
endinterface : scan_if

/* File: design/blank_scan.sv */
// Walks the user flash array byte by byte and reports whether all are erased.
// Assumes the flash answers each read pulse with rvalid some cycles later.
`timescale 1ns/10ps
module blank_scan #(
    parameter int ADDR_W      = boot_inq_pkg::ADDR_W_DEF,
    parameter int ARRAY_BYTES = boot_inq_pkg::ARRAY_BYTES_DEF
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic [7:0]       rdata,
    input  wire logic             rvalid,
    scan_if.scan                  sif
);
    typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} scan_state_e;

    typedef struct packed {
        scan_state_e       st;
        logic [ADDR_W-1:0] addr;
        logic              rd;
        logic              done;
        logic              blank;
    } scan_s;

    localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(ARRAY_BYTES - 1);

    scan_s s_q;
    scan_s s_d;

    // Refuse an array the address width cannot cover
    if (ARRAY_BYTES < 1 || ARRAY_BYTES > (2 ** ADDR_W))
    begin : g_chk
        $error("blank_scan: ARRAY_BYTES does not fit ADDR_W");
    end

    // Stops at the first byte that is not erased; saves time on a dirty array
    always_comb
    begin
        s_d      = s_q;
        s_d.rd   = 1'b0;
        s_d.done = 1'b0;
        case (s_q.st)
            S_IDLE:
            begin
                if (sif.start)
                begin
                    s_d.addr = '0;
                    s_d.st   = S_ISSUE;
                end
            end
            S_ISSUE:
            begin
                s_d.rd = 1'b1;
                s_d.st = S_WAIT;
            end
            S_WAIT:
            begin
                if (rvalid)
                begin
                    if (rdata != boot_inq_pkg::ERASED_BYTE)
                    begin
                        s_d.blank = 1'b0;
                        s_d.done  = 1'b1;
                        s_d.st    = S_IDLE;
                    end
                    else if (s_q.addr == LAST_ADDR)
                    begin
                        s_d.blank = 1'b1;
                        s_d.done  = 1'b1;
                        s_d.st    = S_IDLE;
                    end
                    else
                    begin
                        s_d.addr = s_q.addr + ADDR_W'(1);
                        s_d.st   = S_ISSUE;
                    end
                end
            end
            default:
            begin
                s_d.st = S_IDLE;
            end
        endcase
    end

    // State register with clock enable and synchronous reset
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s_q <= '{st: S_IDLE, addr: '0, rd: 1'b0, done: 1'b0, blank: 1'b0};
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign sif.addr  = s_q.addr;
    assign sif.rd    = s_q.rd;
    assign sif.done  = s_q.done;
    assign sif.blank = s_q.blank;

endmodule : blank_scan

/* File: tb/boot_inq_props.sv */
// Concurrent checks on the responder's top-level ports.
// Assumes CE stays high while a command is in flight.
`timescale 1ns/10ps
module boot_inq_props #(
    parameter int ADDR_W      = 4,
    parameter int ARRAY_BYTES = 16
) (
    input wire logic              MCLK,
    input wire logic              RST_B,
    input wire logic              CE,
    input wire logic              RX_VALID,
    input wire logic [7:0]        RX_DATA,
    input wire logic              TX_READY,
    input wire logic              TX_VALID,
    input wire logic [7:0]        TX_DATA,
    input wire logic              CMD_PASS,
    input wire logic [7:0]        CMD_PASS_DATA,
    input wire logic              BUSY,
    input wire logic              ERR_EVENT,
    input wire logic [7:0]        ERR_CODE_IN,
    input wire logic              ERR_CLEAR,
    input wire logic              ERR_FLAG,
    input wire logic [7:0]        LAST_ERR,
    input wire logic [ADDR_W-1:0] FLASH_ADDR,
    input wire logic              FLASH_RD
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_B);

    // A command byte is only taken while idle
    logic take;
    assign take = CE && RX_VALID && !BUSY;

    AST_INQ_HDR: assert property (take && RX_DATA == 8'h4f |=> BUSY ##1 TX_VALID && TX_DATA == 8'h5f)
        else $error("inquiry header not sent on time");
    AST_BLANK_RD: assert property (take && RX_DATA == 8'h4d |-> ##3 FLASH_RD && FLASH_ADDR == '0)
        else $error("blank check did not start at address zero");
    AST_PASS: assert property (take && RX_DATA != 8'h4d && RX_DATA != 8'h4f
        |=> CMD_PASS && CMD_PASS_DATA == $past(RX_DATA))
        else $error("other byte not handed on");
    AST_TX_HOLD: assert property (TX_VALID && !(CE && TX_READY) |=> TX_VALID && $stable(TX_DATA))
        else $error("response byte dropped before taken");
    AST_TX_GAP: assert property (CE && TX_VALID && TX_READY |=> !TX_VALID)
        else $error("no gap after taken byte");
    AST_RD_PULSE: assert property (CE && FLASH_RD |=> !FLASH_RD)
        else $error("flash read longer than one cycle");
    AST_ERR_SET: assert property (CE && ERR_EVENT && ERR_CODE_IN != 8'h00 |=> ERR_FLAG && LAST_ERR != 8'h00)
        else $error("error event not logged");
    AST_ERR_CLR: assert property (CE && ERR_CLEAR && !ERR_EVENT && !BUSY |=> !ERR_FLAG && LAST_ERR == 8'h00)
        else $error("error clear ignored");
    AST_FREEZE: assert property (!CE |=> $stable(ERR_FLAG) && $stable(BUSY) && $stable(TX_VALID))
        else $error("state moved with clock enable low");
endmodule : boot_inq_props

bind boot_inq_resp boot_inq_props #(.ADDR_W(ADDR_W), .ARRAY_BYTES(ARRAY_BYTES)) props (
    .MCLK(MCLK), .RST_B(RST_B), .CE(CE), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
    .TX_READY(TX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .CMD_PASS(CMD_PASS),
    .CMD_PASS_DATA(CMD_PASS_DATA), .BUSY(BUSY), .ERR_EVENT(ERR_EVENT),
    .ERR_CODE_IN(ERR_CODE_IN), .ERR_CLEAR(ERR_CLEAR), .ERR_FLAG(ERR_FLAG),
    .LAST_ERR(LAST_ERR), .FLASH_ADDR(FLASH_ADDR), .FLASH_RD(FLASH_RD));

/* File: tb/flash_model.sv */
// Behavioural user flash array answering single read pulses.
// Assumes one read outstanding at a time; one byte may be made dirty.
`timescale 1ns/10ps
module flash_model #(
    parameter int ADDR_W = 4
) (
    input  wire logic              clk,
    input  wire logic              rd,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [1:0]        lat,
    input  wire logic              dirty_en,
    input  wire logic [ADDR_W-1:0] dirty_idx,
    output logic [7:0]             rdata,
    output logic                   rvalid
);
    logic       pend_q;
    logic [1:0] wait_q;
    logic [7:0] word_q;

    initial
    begin
        rvalid = 1'b0;
        rdata  = 8'h5a;
        pend_q = 1'b0;
        wait_q = 2'h0;
        word_q = 8'h00;
    end

    // No write path: units are never programmed twice or while dirty
    // Data inverts every cycle when not valid, so a stale sample after an ff read looks erased every other cycle
    always @(posedge clk)
    begin
        rvalid <= 1'b0;
        rdata  <= ~rdata;
        if (rd)
        begin
            pend_q <= 1'b1;
            wait_q <= lat;
            word_q <= (dirty_en && addr == dirty_idx) ? 8'h00 : 8'hff;
        end
        else if (pend_q)
        begin
            if (wait_q == 2'h0)
            begin
                rvalid <= 1'b1;
                rdata  <= word_q;
                pend_q <= 1'b0;
            end
            else
                wait_q <= wait_q - 2'h1;
        end
    end
endmodule : flash_model

/* File: tb/tb_boot_state_inquiry_blank_check.sv */
// Self-checking bench for the blank-check and state-inquiry responder.
// Assumes a 16-byte array; the host side is driven here, flash by a model.
`timescale 1ns/10ps
module tb_boot_state_inquiry_blank_check;
    localparam int AW = 4;
    logic          mclk = 1'b0;
    logic          rst_b, ce, rx_valid, tx_ready, err_event, err_clear;
    logic          tx_valid, cmd_pass, busy, err_flag, flash_rd, flash_rvalid;
    logic          dirty_en, slow;
    logic [7:0]    rx_data, tx_data, cmd_pass_data, err_code_in, last_err, flash_rdata;
    logic [2:0]    boot_phase;
    logic [1:0]    lat;
    logic [AW-1:0] flash_addr, dirty_idx;
    logic [7:0]    frm [5];
    int            got_n, mismatches, checks_done;
    logic [7:0]    codes [8] = '{8'h11, 8'h12, 8'h13, 8'h1f, 8'h31, 8'h3f, 8'h4f, 8'h5f};
    logic [7:0]    errs [17] = '{8'h11, 8'h12, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h27, 8'h29,
                                 8'h2a, 8'h2b, 8'h51, 8'h52, 8'h53, 8'h54, 8'h80, 8'hff};

    // Clock and a ready line that stalls every other cycle when slow is set
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) tx_ready <= slow ? ~tx_ready : 1'b1;

    boot_inq_resp #(.ADDR_W(AW), .ARRAY_BYTES(16)) DUT (
        .MCLK(mclk), .RST_B(rst_b), .CE(ce), .RX_VALID(rx_valid), .RX_DATA(rx_data),
        .TX_READY(tx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data), .CMD_PASS(cmd_pass),
        .CMD_PASS_DATA(cmd_pass_data), .BUSY(busy), .BOOT_PHASE(boot_phase),
        .ERR_EVENT(err_event), .ERR_CODE_IN(err_code_in), .ERR_CLEAR(err_clear),
        .ERR_FLAG(err_flag), .LAST_ERR(last_err), .FLASH_ADDR(flash_addr),
        .FLASH_RD(flash_rd), .FLASH_RDATA(flash_rdata), .FLASH_RVALID(flash_rvalid));

    flash_model #(.ADDR_W(AW)) flash (.clk(mclk), .rd(flash_rd), .addr(flash_addr), .lat(lat),
        .dirty_en(dirty_en), .dirty_idx(dirty_idx), .rdata(flash_rdata), .rvalid(flash_rvalid));

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic send(input logic [7:0] b);
        @(posedge mclk);
        rx_valid <= 1'b1;
        rx_data  <= b;
        @(posedge mclk);
        rx_valid <= 1'b0;
    endtask : send

    // Collects taken bytes under a bound so a silent responder cannot hang
    task automatic recv(input int n);
        int k;
        k = 0;
        got_n = 0;
        while (got_n < n && k < 400)
        begin
            @(posedge mclk);
            k++;
            if (ce === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1)
            begin
                frm[got_n] = tx_data;
                got_n++;
            end
        end
        chk8("frame length", 8'(n), 8'(got_n));
        repeat (3) @(posedge mclk);
        chk8("busy", 8'h00, {7'h0, busy});
        chk8("tx valid", 8'h00, {7'h0, tx_valid});
    endtask : recv

    task automatic t_inquiry(input logic [2:0] ph, input logic [7:0] err);
        @(posedge mclk);
        boot_phase <= ph;
        send(8'h4f);
        recv(5);
        chk8("inq header", 8'h5f, frm[0]);
        chk8("inq size", 8'h02, frm[1]);
        chk8("inq state", codes[ph], frm[2]);
        chk8("inq error", err, frm[3]);
        chk8("inq sum", 8'h00, frm[0] + frm[1] + frm[2] + frm[3] + frm[4]);
    endtask : t_inquiry

    task automatic t_blank(input logic d_en, input logic [AW-1:0] d_idx, input logic [1:0] l);
        @(posedge mclk);
        dirty_en  <= d_en;
        dirty_idx <= d_idx;
        lat       <= l;
        send(8'h4d);
        recv(d_en ? 2 : 1);
        chk8("blank head", d_en ? 8'hcd : 8'h06, frm[0]);
        if (d_en)
            chk8("blank code", 8'h52, frm[1]);
        chk8("blank flag", {7'h0, d_en}, {7'h0, err_flag});
    endtask : t_blank

    task automatic raise(input logic [7:0] code, input logic en);
        @(posedge mclk);
        err_event   <= 1'b1;
        err_code_in <= code;
        ce          <= en;
        @(posedge mclk);
        err_event <= 1'b0;
        ce        <= 1'b1;
        @(posedge mclk);
    endtask : raise

    task automatic clear_err;
        @(posedge mclk);
        err_clear <= 1'b1;
        @(posedge mclk);
        err_clear <= 1'b0;
        @(posedge mclk);
        chk8("cleared flag", 8'h00, {7'h0, err_flag});
    endtask : clear_err

    // Every listed code is logged as given, an unlisted one as command error
    task automatic t_codes;
        foreach (errs[i])
        begin
            raise(errs[i], 1'b1);
            chk8("last error", errs[i], last_err);
        end
        raise(8'h33, 1'b1);
        chk8("unlisted code", 8'h80, last_err);
        clear_err();
        raise(8'h00, 1'b1);
        chk8("no error flag", 8'h00, {7'h0, err_flag});
        raise(8'h29, 1'b0);
        chk8("frozen flag", 8'h00, {7'h0, err_flag});
    endtask : t_codes

    // A second command while busy must vanish; a foreign byte goes on
    task automatic t_other;
        send(8'h4f);
        // First byte goes out while the refused byte is still being sent
        fork
            recv(5);
            send(8'h4d);
        join
        chk8("refused blank", 8'h5f, frm[0]);
        send(8'h50);
        @(posedge mclk);
        chk8("pass pulse", 8'h01, {7'h0, cmd_pass});
        chk8("pass data", 8'h50, cmd_pass_data);
    endtask : t_other

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    initial
    begin
        #500000;
        mismatches++;
        print_verdict();
    end

    initial
    begin
        {rst_b, rx_valid, err_event, err_clear, dirty_en, slow, tx_ready} = '0;
        {rx_data, err_code_in, boot_phase, lat, dirty_idx} = '0;
        ce = 1'b1;
        mismatches = 0;
        checks_done = 0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        chk8("reset outputs", 8'h00, {3'h0, tx_valid, busy, err_flag, flash_rd, cmd_pass});
        for (int p = 0; p < 8; p++)
            t_inquiry(3'(p), 8'h00);
        slow <= 1'b1;
        t_inquiry(3'h3, 8'h00);
        t_blank(1'b0, 4'h0, 2'h3);
        slow <= 1'b0;
        t_blank(1'b0, 4'h0, 2'h0);
        t_blank(1'b1, 4'hf, 2'h1);
        t_inquiry(3'h4, 8'h01);
        chk8("blank log", 8'h52, last_err);
        clear_err();
        t_blank(1'b1, 4'h0, 2'h0);
        clear_err();
        t_codes();
        t_other();
        print_verdict();
    end
endmodule : tb_boot_state_inquiry_blank_check
